// [hdl/eic_pkg.sv]
// Shared constants for the external event and interrupt control block
package eic_pkg;
	// Event lines: 16 pin channels, supply monitor, two comparators, rtc and timer wake
	localparam int NUM_PIN_CH = 16;
	localparam int NUM_LINES = 21;
	localparam int LINE_SUPPLY = 16;
	localparam int LINE_CMP1 = 17;
	localparam int LINE_CMP2 = 18;
	localparam int LINE_RTC = 19;
	localparam int LINE_LOW_POWER_TIMER = 20;
	localparam int SEL_W = 5;
	// Nested controller sources: nmi, internal exceptions, maskable requests
	localparam int NUM_IRQ = 32;
	localparam int NUM_EXC = 10;
	localparam int NUM_SRC = 1 + NUM_EXC + NUM_IRQ;
	localparam int NUM_PRIO = 4;
	localparam int LVL_W = 3;
	localparam int NUM_LVL = 2 + NUM_PRIO;
	localparam logic [2:0] LVL_NMI = 3'h0;
	localparam logic [2:0] LVL_EXC = 3'h1;
	localparam logic [2:0] LVL_IRQ0 = 3'h2;
	localparam logic [2:0] LVL_THREAD = 3'h6;
	localparam logic [5:0] NUM_NMI = 6'h02;
	localparam logic [5:0] NUM_EXC0 = 6'h03;
	localparam logic [5:0] NUM_IRQ0 = 6'h10;
	// Register byte offsets
	localparam logic [7:0] OFS_EV_RISE = 8'h00;
	localparam logic [7:0] OFS_EV_FALL = 8'h04;
	localparam logic [7:0] OFS_EV_IRQ_EN = 8'h08;
	localparam logic [7:0] OFS_EV_WAKE_EN = 8'h0c;
	localparam logic [7:0] OFS_EV_PEND = 8'h10;
	localparam logic [7:0] OFS_PIN_SEL0 = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN = 8'h24;
	localparam logic [7:0] OFS_IRQ_PEND = 8'h28;
	localparam logic [7:0] OFS_IRQ_PRIO0 = 8'h2c;
	localparam logic [7:0] OFS_VTOR = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam int SEL_PER_WORD = 4;
	localparam int SEL_FIELD = 8;
	localparam int PRIO_PER_WORD = 16;
	// Values after reset
	localparam logic [20:0] RST_EV_RISE = 21'h180000;
	localparam logic [31:0] RST_VTOR = 32'h00000000;
	typedef enum logic [1:0] {
		EIC_IDLE = 2'b00,
		EIC_DECIDE = 2'b01,
		EIC_OFFER = 2'b11
	} eic_disp_e;
endpackage : eic_pkg

// [hdl/eic_edge_catch.sv]
// Edge catcher for one event line that also catches pulses shorter than a clock period
`timescale 1ns/100ps
module eic_edge_catch (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Line and edge choice
	input wire logic line_in,
	input wire logic rise_en,
	input wire logic fall_en,
	// Detected edge, one cycle
	output logic edge_evt
);
	typedef struct packed {
		logic [2:0] rs;
		logic [2:0] fs;
		logic rseen;
		logic fseen;
		logic evt;
	} eic_edge_s;
	eic_edge_s st, next_st;
	logic rtog, ftog;

	// The line itself clocks these toggles, so a sub-cycle pulse still flips them
	always_ff @(posedge line_in or negedge presetn) begin
		if (!presetn) rtog <= 1'b0;
		else rtog <= ~rtog;
	end
	always_ff @(negedge line_in or negedge presetn) begin
		if (!presetn) ftog <= 1'b0;
		else ftog <= ~ftog;
	end

	always_comb begin
		next_st = st;
		next_st.rs = {st.rs[1:0], rtog};
		next_st.fs = {st.fs[1:0], ftog};
		next_st.evt = 1'b0;
		// A toggle counts once stages two and three agree
		if (st.rs[1] == st.rs[2] && st.rs[2] != st.rseen) begin
			next_st.rseen = st.rs[2];
			next_st.evt = rise_en; // see R2
		end
		if (st.fs[1] == st.fs[2] && st.fs[2] != st.fseen) begin
			next_st.fseen = st.fs[2];
			if (fall_en) next_st.evt = 1'b1; // see R5
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) st <= '0;
		else st <= next_st;
	end

	assign edge_evt = st.evt;
endmodule : eic_edge_catch

// [hdl/eic_prio_arb.sv]
// Picks the pending source with the best (lowest) level, lowest index on ties
`timescale 1ns/100ps
module eic_prio_arb #(
	parameter int N = 43,
	parameter int LW = 3,
	parameter int IW = 6
) (
	// Requests
	input wire logic [N-1:0] req,
	input wire logic [N-1:0][LW-1:0] lvl,
	// Winner
	output logic win_valid,
	output logic [IW-1:0] win_idx,
	output logic [LW-1:0] win_lvl
);
	generate
		if (N > (1 << IW)) begin : g_chk
			$error("eic_prio_arb: index too narrow");
		end
	endgenerate

	always_comb begin
		win_valid = 1'b0;
		win_idx = '0;
		win_lvl = '1;
		for (int i = 0; i < N; i++) begin
			// Strict compare keeps the lower index on equal levels
			if (req[i] && (!win_valid || lvl[i] < win_lvl)) begin
				win_valid = 1'b1;
				win_idx = IW'(i);
				win_lvl = lvl[i];
			end
		end
	end
endmodule : eic_prio_arb

// [hdl/eic_ctrl.sv]
// External event controller and nested vectored interrupt controller with apb registers
//
// Behaviour
// R1 - Lines: 16 pins, monitor, two comparators, wakes
// R2 - Pin, monitor, comparator lines pick edge(s)
// R3 - Each pin channel selects any gpio pin
// R4 - Each line masked on its own
// R5 - Pulses shorter than clock period are caught
// R6 - Events latched in pending flags across stop
// R7 - Unmasked pending line requests stop wake-up
// R8 - One nmi and 32 maskable inputs
// R9 - Ten internal exception sources also handled
// R10 - Four programmable priority levels arbitrate requests
// R11 - Later higher-priority request dispatched first; an offer latched in EIC_DECIDE stands until accepted, a later one waits
// R12 - Higher priority preempts running lower handler
// R13 - Tail-chain pending handler without context restore
// R14 - Vector fetched at table base plus number
// R15 - Supply monitor drives line 16, edge chooses direction
// R16 - Pending stays until written clear; set wins
// R17 - Line request equals pending and mask
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module eic_ctrl #(
	parameter int NUM_PINS = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources
	input wire logic [NUM_PINS-1:0] gpio_in,
	input wire logic supply_voltage_monitor,
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	input wire logic rtc_wake,
	input wire logic low_power_timer_wake,
	// Event line requests and wake-up
	output logic [eic_pkg::NUM_LINES-1:0] line_irq,
	output logic wake_req,
	// Interrupt sources
	input wire logic nmi_in,
	input wire logic [eic_pkg::NUM_EXC-1:0] exc_req,
	input wire logic [eic_pkg::NUM_IRQ-1:0] irq_req,
	// Processor core dispatch
	output logic disp_valid,
	output logic [5:0] disp_num,
	output logic [31:0] disp_vector,
	output logic disp_tail,
	input wire logic disp_ack,
	input wire logic handler_done,
	output logic ctx_restore
);
	localparam int NL = eic_pkg::NUM_LINES;
	localparam int NS = eic_pkg::NUM_SRC;

	generate
		if (NUM_PINS < eic_pkg::NUM_PIN_CH || NUM_PINS > (1 << eic_pkg::SEL_W)) begin : g_chk
			$error("eic_ctrl: NUM_PINS out of range");
		end
	endgenerate

	typedef struct packed {
		logic [NL-1:0] rise;
		logic [NL-1:0] fall;
		logic [NL-1:0] ev_irq_en;
		logic [NL-1:0] ev_wake_en;
		logic [NL-1:0] ev_pend;
		logic [eic_pkg::NUM_PIN_CH-1:0][eic_pkg::SEL_W-1:0] pin_sel;
		logic [eic_pkg::NUM_IRQ-1:0] irq_en;
		logic [eic_pkg::NUM_IRQ-1:0][1:0] prio;
		logic [31:0] vtor;
		logic [NS-1:0] src_pend;
		logic [eic_pkg::NUM_LVL-1:0] active;
		eic_pkg::eic_disp_e state;
		logic [5:0] off_idx;
		logic [2:0] off_lvl;
		logic [5:0] num;
		logic [31:0] vector;
		logic tail;
		logic restore;
		logic [31:0] rdata;
		logic err;
	} eic_ctrl_s;
	eic_ctrl_s st, next_st;

	// Channel inputs after selection
	logic [NL-1:0] line_raw;
	logic [NL-1:0] line_evt;
	logic [NL-1:0] rise_eff;
	logic [NL-1:0] fall_eff;
	logic setup;
	logic wr_en;
	logic [NS-1:0] src_req;
	logic [NS-1:0][2:0] src_lvl;
	logic best_valid;
	logic [5:0] best_idx;
	logic [2:0] best_lvl;
	logic [2:0] cur_lvl;
	logic [2:0] cur_lvl_after;
	logic [eic_pkg::NUM_LVL-1:0] active_after;
	logic preempt_now;
	logic preempt_after;

	always_comb begin
		for (int c = 0; c < eic_pkg::NUM_PIN_CH; c++) begin
			// Changing a select while the pin differs may itself look like an edge
			line_raw[c] = gpio_in[st.pin_sel[c]]; // see R3
		end
		line_raw[eic_pkg::LINE_SUPPLY] = supply_voltage_monitor; // see R15
		line_raw[eic_pkg::LINE_CMP1] = cmp1_out;
		line_raw[eic_pkg::LINE_CMP2] = cmp2_out;
		line_raw[eic_pkg::LINE_RTC] = rtc_wake;
		line_raw[eic_pkg::LINE_LOW_POWER_TIMER] = low_power_timer_wake; // see R1
	end

	// Wake lines only count rising edges; their edge bits are fixed
	always_comb begin
		rise_eff = st.rise;
		fall_eff = st.fall;
		rise_eff[eic_pkg::LINE_RTC] = 1'b1;
		rise_eff[eic_pkg::LINE_LOW_POWER_TIMER] = 1'b1;
		fall_eff[eic_pkg::LINE_RTC] = 1'b0;
		fall_eff[eic_pkg::LINE_LOW_POWER_TIMER] = 1'b0;
	end

	generate
		for (genvar l = 0; l < NL; l++) begin : g_line
			eic_edge_catch u_catch (
				.pclk(pclk),
				.presetn(presetn),
				.line_in(line_raw[l]),
				.rise_en(rise_eff[l]),
				.fall_en(fall_eff[l]),
				.edge_evt(line_evt[l])
			);
		end
	endgenerate

	// Source table: nmi, then internal exceptions, then maskable inputs
	always_comb begin
		src_req[0] = st.src_pend[0];
		src_lvl[0] = eic_pkg::LVL_NMI;
		for (int e = 0; e < eic_pkg::NUM_EXC; e++) begin
			src_req[1 + e] = st.src_pend[1 + e]; // see R9
			src_lvl[1 + e] = eic_pkg::LVL_EXC;
		end
		for (int i = 0; i < eic_pkg::NUM_IRQ; i++) begin
			src_req[1 + eic_pkg::NUM_EXC + i] = st.src_pend[1 + eic_pkg::NUM_EXC + i] & st.irq_en[i]; // see R8
			src_lvl[1 + eic_pkg::NUM_EXC + i] = eic_pkg::LVL_IRQ0 + {1'b0, st.prio[i]}; // see R10
		end
	end

	eic_prio_arb #(
		.N(NS),
		.LW(eic_pkg::LVL_W),
		.IW(6)
	) u_arb (
		.req(src_req),
		.lvl(src_lvl),
		.win_valid(best_valid),
		.win_idx(best_idx),
		.win_lvl(best_lvl)
	);

	// Running level is the best active level; a finishing handler drops its own
	always_comb begin
		cur_lvl = eic_pkg::LVL_THREAD;
		cur_lvl_after = eic_pkg::LVL_THREAD;
		active_after = st.active;
		for (int v = eic_pkg::NUM_LVL - 1; v >= 0; v--) begin
			if (st.active[v]) cur_lvl = 3'(v);
		end
		for (int v = 0; v < eic_pkg::NUM_LVL; v++) begin
			if (3'(v) == cur_lvl) active_after[v] = 1'b0;
		end
		for (int v = eic_pkg::NUM_LVL - 1; v >= 0; v--) begin
			if (active_after[v]) cur_lvl_after = 3'(v);
		end
		preempt_now = best_valid && (best_lvl < cur_lvl); // see R12
		preempt_after = best_valid && (best_lvl < cur_lvl_after);
	end

	function automatic logic [5:0] src_num(input logic [5:0] idx);
		if (idx == 6'h00) src_num = eic_pkg::NUM_NMI;
		else if (idx <= 6'(eic_pkg::NUM_EXC)) src_num = eic_pkg::NUM_EXC0 + idx - 6'h01;
		else src_num = eic_pkg::NUM_IRQ0 + idx - 6'(1 + eic_pkg::NUM_EXC);
	endfunction : src_num

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;

	always_comb begin
		logic [7:0] a;
		logic [NL-1:0] ev_clr;
		logic [eic_pkg::NUM_IRQ-1:0] irq_clr;
		logic [NS-1:0] ack_clr;
		int w;
		a = paddr;
		ev_clr = '0;
		irq_clr = '0;
		ack_clr = '0;
		w = 0;
		next_st = st;
		next_st.restore = 1'b0;

		// Register writes take effect in the access phase
		if (wr_en) begin
			case (a)
				eic_pkg::OFS_EV_RISE: next_st.rise = pwdata[NL-1:0];
				eic_pkg::OFS_EV_FALL: next_st.fall = pwdata[NL-1:0];
				eic_pkg::OFS_EV_IRQ_EN: next_st.ev_irq_en = pwdata[NL-1:0]; // see R4
				eic_pkg::OFS_EV_WAKE_EN: next_st.ev_wake_en = pwdata[NL-1:0];
				eic_pkg::OFS_EV_PEND: ev_clr = pwdata[NL-1:0];
				eic_pkg::OFS_IRQ_EN: next_st.irq_en = pwdata;
				eic_pkg::OFS_IRQ_PEND: irq_clr = pwdata;
				eic_pkg::OFS_VTOR: next_st.vtor = {pwdata[31:2], 2'b00};
				default: begin
				end
			endcase
			for (int k = 0; k < eic_pkg::NUM_PIN_CH / eic_pkg::SEL_PER_WORD; k++) begin
				if (a == eic_pkg::OFS_PIN_SEL0 + 8'(4 * k)) begin
					for (int j = 0; j < eic_pkg::SEL_PER_WORD; j++) begin
						w = k * eic_pkg::SEL_PER_WORD + j;
						next_st.pin_sel[w] = pwdata[j * eic_pkg::SEL_FIELD +: eic_pkg::SEL_W];
					end
				end
			end
			for (int k = 0; k < eic_pkg::NUM_IRQ / eic_pkg::PRIO_PER_WORD; k++) begin
				if (a == eic_pkg::OFS_IRQ_PRIO0 + 8'(4 * k)) begin
					for (int j = 0; j < eic_pkg::PRIO_PER_WORD; j++) begin
						next_st.prio[k * eic_pkg::PRIO_PER_WORD + j] = pwdata[2 * j +: 2];
					end
				end
			end
		end

		// Write one to clear; a same-cycle edge still sets the flag
		next_st.ev_pend = (st.ev_pend & ~ev_clr) | line_evt; // see R6 see R16

		// Dispatch sequence
		case (st.state)
			eic_pkg::EIC_IDLE: begin
				if (handler_done) begin
					next_st.active = active_after;
					next_st.state = eic_pkg::EIC_DECIDE;
				end else if (preempt_now) begin
					next_st.state = eic_pkg::EIC_DECIDE;
				end
			end
			eic_pkg::EIC_DECIDE: begin
				if (preempt_now) begin
					// Best source is latched here so a later, better one waits for the next offer
					next_st.off_idx = best_idx; // see R11
					next_st.off_lvl = best_lvl;
					next_st.num = src_num(best_idx);
					next_st.vector = st.vtor + {24'h000000, src_num(best_idx), 2'b00}; // see R14
					next_st.tail = st.tail;
					next_st.state = eic_pkg::EIC_OFFER;
				end else begin
					next_st.restore = st.tail;
					next_st.tail = 1'b0;
					next_st.state = eic_pkg::EIC_IDLE;
				end
			end
			eic_pkg::EIC_OFFER: begin
				if (disp_ack) begin
					ack_clr[st.off_idx] = 1'b1;
					next_st.active[st.off_lvl] = 1'b1;
					next_st.tail = 1'b0;
					next_st.state = eic_pkg::EIC_IDLE;
				end
			end
			default: next_st.state = eic_pkg::EIC_IDLE;
		endcase
		// A return seen in idle marks the next offer as a chained entry
		if (st.state == eic_pkg::EIC_IDLE && handler_done) next_st.tail = 1'b1; // see R13

		// Request inputs are levels; a request still high re-pends after its clear
		next_st.src_pend = (st.src_pend & ~ack_clr & ~{irq_clr, {(1 + eic_pkg::NUM_EXC){1'b0}}})
			| {irq_req, exc_req, nmi_in};

		// Read data is captured in the setup phase
		if (setup) begin
			next_st.err = 1'b0;
			next_st.rdata = '0;
			case (a)
				eic_pkg::OFS_EV_RISE: next_st.rdata[NL-1:0] = rise_eff;
				eic_pkg::OFS_EV_FALL: next_st.rdata[NL-1:0] = fall_eff;
				eic_pkg::OFS_EV_IRQ_EN: next_st.rdata[NL-1:0] = st.ev_irq_en;
				eic_pkg::OFS_EV_WAKE_EN: next_st.rdata[NL-1:0] = st.ev_wake_en;
				eic_pkg::OFS_EV_PEND: next_st.rdata[NL-1:0] = st.ev_pend;
				eic_pkg::OFS_IRQ_EN: next_st.rdata = st.irq_en;
				eic_pkg::OFS_IRQ_PEND: next_st.rdata = st.src_pend[NS-1 -: eic_pkg::NUM_IRQ];
				eic_pkg::OFS_VTOR: next_st.rdata = st.vtor;
				eic_pkg::OFS_STATUS: next_st.rdata = {16'h0000, 2'b00, st.state, 1'b0, cur_lvl,
					2'b00, st.active};
				default: next_st.err = 1'b1;
			endcase
			for (int k = 0; k < eic_pkg::NUM_PIN_CH / eic_pkg::SEL_PER_WORD; k++) begin
				if (a == eic_pkg::OFS_PIN_SEL0 + 8'(4 * k)) begin
					next_st.err = 1'b0;
					for (int j = 0; j < eic_pkg::SEL_PER_WORD; j++) begin
						next_st.rdata[j * eic_pkg::SEL_FIELD +: eic_pkg::SEL_W] =
							st.pin_sel[k * eic_pkg::SEL_PER_WORD + j];
					end
				end
			end
			for (int k = 0; k < eic_pkg::NUM_IRQ / eic_pkg::PRIO_PER_WORD; k++) begin
				if (a == eic_pkg::OFS_IRQ_PRIO0 + 8'(4 * k)) begin
					next_st.err = 1'b0;
					for (int j = 0; j < eic_pkg::PRIO_PER_WORD; j++) begin
						next_st.rdata[2 * j +: 2] = st.prio[k * eic_pkg::PRIO_PER_WORD + j];
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.rise <= eic_pkg::RST_EV_RISE;
			st.vtor <= eic_pkg::RST_VTOR;
			st.state <= eic_pkg::EIC_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && st.err;
	assign line_irq = st.ev_pend & st.ev_irq_en; // see R17 see R4
	assign wake_req = |(st.ev_pend & st.ev_wake_en); // see R7
	assign disp_valid = (st.state == eic_pkg::EIC_OFFER);
	assign disp_num = st.num;
	assign disp_vector = st.vector;
	assign disp_tail = st.tail;
	assign ctx_restore = st.restore;
endmodule : eic_ctrl

// [verification/eic_ctrl_monitor.sv]
// Assertion checker for the event and interrupt control block
`timescale 1ns/100ps
module eic_ctrl_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Events
	input wire logic [eic_pkg::NUM_LINES-1:0] line_irq,
	input wire logic wake_req,
	input wire logic nmi_in,
	// Dispatch
	input wire logic disp_valid,
	input wire logic [5:0] disp_num,
	input wire logic [31:0] disp_vector,
	input wire logic disp_tail,
	input wire logic disp_ack,
	input wire logic handler_done,
	input wire logic ctx_restore
);
	logic wr_acc;
	assign wr_acc = psel && penable && pwrite && pready;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Only a clear or a mask write may drop a line request
	property p_line_hold;
		|($past(line_irq) & ~line_irq) |-> $past(wr_acc)
			&& ($past(paddr) == eic_pkg::OFS_EV_PEND || $past(paddr) == eic_pkg::OFS_EV_IRQ_EN);
	endproperty
	a_line_hold: assert property (p_line_hold) else $error("line request dropped without write");
	property p_wake_hold;
		$fell(wake_req) |-> $past(wr_acc)
			&& ($past(paddr) == eic_pkg::OFS_EV_PEND || $past(paddr) == eic_pkg::OFS_EV_WAKE_EN);
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake request dropped without write");
	property p_offer_hold;
		disp_valid && !disp_ack |=> disp_valid && $stable(disp_num) && $stable(disp_vector) && $stable(disp_tail);
	endproperty
	a_offer_hold: assert property (p_offer_hold) else $error("offer changed before acceptance");
	property p_offer_drop;
		disp_valid && disp_ack |=> !disp_valid;
	endproperty
	a_offer_drop: assert property (p_offer_drop) else $error("offer stayed after acceptance");
	property p_ctx;
		ctx_restore |-> !disp_valid && ($past(handler_done, 2) || $past(handler_done, 3) || $past(handler_done));
	endproperty
	a_ctx: assert property (p_ctx) else $error("context restore without handler end");
	property p_tail;
		$rose(disp_valid) && disp_tail |-> $past(handler_done, 2) || $past(handler_done, 3) || $past(handler_done);
	endproperty
	a_tail: assert property (p_tail) else $error("chained offer without handler end");
	property p_nmi;
		$rose(nmi_in) |-> ##[1:20] (disp_valid && disp_num == eic_pkg::NUM_NMI);
	endproperty
	a_nmi: assert property (p_nmi) else $error("non-maskable request not offered");
	property p_slverr;
		psel && penable |-> pslverr == (paddr > 8'h38 || paddr[1:0] != 2'b00);
	endproperty
	a_slverr: assert property (p_slverr) else $error("error response wrong for address");
	c_tail: cover property (disp_valid && disp_tail);
	c_ctx: cover property (ctx_restore);
	c_err: cover property (psel && penable && pslverr);
endmodule : eic_ctrl_monitor

bind eic_ctrl eic_ctrl_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .line_irq(line_irq),
	.wake_req(wake_req), .nmi_in(nmi_in), .disp_valid(disp_valid), .disp_num(disp_num),
	.disp_vector(disp_vector), .disp_tail(disp_tail), .disp_ack(disp_ack), .handler_done(handler_done),
	.ctx_restore(ctx_restore));

// [verification/eic_core_model.sv]
// Processor core model that accepts offers and ends handlers on command
`timescale 1ns/100ps
module eic_core_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Dispatch handshake
	input wire logic disp_valid,
	output logic disp_ack,
	output logic handler_done,
	// Bench control
	input wire logic [3:0] ack_wait,
	input wire logic done_cmd
);
	logic [3:0] cnt;
	// A slow answer keeps the offer standing so the bench can look at it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			disp_ack <= 1'b0;
			handler_done <= 1'b0;
		end else begin
			handler_done <= done_cmd;
			disp_ack <= 1'b0;
			cnt <= 4'h0;
			if (disp_valid && !disp_ack && cnt >= ack_wait) begin
				disp_ack <= 1'b1;
			end else if (disp_valid && !disp_ack) begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule : eic_core_model

// [verification/eic_ctrl_test.sv]
// Self-checking bench for the event and interrupt control block
`timescale 1ns/100ps
module eic_ctrl_test;
	typedef struct {
		int line;
		logic rise;
		logic fall;
		logic v0;
		logic v1;
		logic ex;
	} eic_row_s;
	// Line, rise enable, fall enable, start level, end level, pending expected
	eic_row_s rows [11] = '{'{0, 1, 0, 0, 1, 1}, '{0, 1, 0, 1, 0, 0}, '{0, 0, 1, 1, 0, 1}, '{9, 1, 1, 0, 1, 1},
		'{16, 1, 0, 0, 1, 1}, '{16, 0, 1, 0, 1, 0}, '{16, 0, 1, 1, 0, 1}, '{17, 0, 1, 1, 0, 1},
		'{18, 1, 1, 1, 0, 1}, '{19, 0, 0, 0, 1, 1}, '{20, 0, 0, 0, 1, 1}};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] gpio_in = 32'h0;
	logic supply = 1'b0;
	logic cmp1 = 1'b0;
	logic cmp2 = 1'b0;
	logic rtc = 1'b0;
	logic lpt = 1'b0;
	logic nmi_in = 1'b0;
	logic [9:0] exc_req = 10'h0;
	logic [31:0] irq_req = 32'h0;
	logic done_cmd = 1'b0;
	logic [3:0] ack_wait = 4'h0;
	logic [31:0] prdata, disp_vector, m, q;
	logic pready, pslverr, wake_req, disp_valid, disp_tail, disp_ack, handler_done, ctx_restore, e;
	logic [eic_pkg::NUM_LINES-1:0] line_irq;
	logic [5:0] disp_num;
	int failures = 0;
	int compares = 0;
	always #5 pclk = ~pclk;
	eic_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
		.supply_voltage_monitor(supply), .cmp1_out(cmp1), .cmp2_out(cmp2), .rtc_wake(rtc),
		.low_power_timer_wake(lpt), .line_irq(line_irq), .wake_req(wake_req), .nmi_in(nmi_in), .exc_req(exc_req),
		.irq_req(irq_req), .disp_valid(disp_valid), .disp_num(disp_num), .disp_vector(disp_vector),
		.disp_tail(disp_tail), .disp_ack(disp_ack), .handler_done(handler_done), .ctx_restore(ctx_restore));
	eic_core_model i_core (.pclk(pclk), .presetn(presetn), .disp_valid(disp_valid), .disp_ack(disp_ack),
		.handler_done(handler_done), .ack_wait(ack_wait), .done_cmd(done_cmd));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
		output logic re);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1) failures++;
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, q, e);
		check("prdata", q, exp);
	endtask : rd
	task automatic drive_line(input int l, input logic v);
		case (l)
			16: supply <= v;
			17: cmp1 <= v;
			18: cmp2 <= v;
			19: rtc <= v;
			20: lpt <= v;
			default: gpio_in[0] <= v;
		endcase
	endtask : drive_line
	task automatic raise(input logic n, input logic [9:0] x, input logic [31:0] r);
		nmi_in <= n;
		exc_req <= x;
		irq_req <= r;
		@(posedge pclk);
		nmi_in <= 1'b0;
		exc_req <= 10'h0;
		irq_req <= 32'h0;
	endtask : raise
	task automatic take(input logic [5:0] num, input logic tail);
		int n;
		n = 0;
		while (disp_valid !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (disp_valid !== 1'b1) failures++;
		check("disp_num", {26'h0, disp_num}, {26'h0, num});
		check("disp_vector", disp_vector, 32'h200 + {24'h0, num, 2'b00});
		check("disp_tail", {31'h0, disp_tail}, {31'h0, tail});
		while (disp_valid === 1'b1 && n < 80) begin
			@(posedge pclk);
			n++;
		end
		if (disp_valid === 1'b1) failures++;
	endtask : take
	task automatic end_handler(input logic exp_ctx);
		logic seen;
		seen = 1'b0;
		done_cmd <= 1'b1;
		@(posedge pclk);
		done_cmd <= 1'b0;
		repeat (6) begin
			@(posedge pclk);
			seen = seen | (ctx_restore === 1'b1);
		end
		check("ctx_restore", {31'h0, seen}, {31'h0, exp_ctx});
	endtask : end_handler
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("line_irq", {11'h0, line_irq}, 32'h0);
		rd(eic_pkg::OFS_EV_RISE, {11'h0, eic_pkg::RST_EV_RISE});
		rd(eic_pkg::OFS_VTOR, eic_pkg::RST_VTOR);
		apb(1'b0, 8'h3c, 32'h0, q, e);
		check("pslverr", {31'h0, e}, 32'h1);
		foreach (rows[i]) begin
			m = 32'h1 << rows[i].line;
			wr(eic_pkg::OFS_EV_RISE, rows[i].rise ? m : 32'h0);
			wr(eic_pkg::OFS_EV_FALL, rows[i].fall ? m : 32'h0);
			wr(eic_pkg::OFS_EV_IRQ_EN, m);
			wr(eic_pkg::OFS_EV_WAKE_EN, m);
			drive_line(rows[i].line, rows[i].v0);
			repeat (8) @(posedge pclk);
			wr(eic_pkg::OFS_EV_PEND, 32'h001f_ffff);
			drive_line(rows[i].line, rows[i].v1);
			repeat (8) @(posedge pclk);
			rd(eic_pkg::OFS_EV_PEND, rows[i].ex ? m : 32'h0);
			check("line_irq", {11'h0, line_irq}, rows[i].ex ? m : 32'h0);
			check("wake_req", {31'h0, wake_req}, {31'h0, rows[i].ex});
			drive_line(rows[i].line, 1'b0);
		end
		// Channel 5 follows pin 23; a sub-cycle pulse must still be caught
		wr(eic_pkg::OFS_PIN_SEL0 + 8'h04, 32'd23 << 8);
		wr(eic_pkg::OFS_EV_RISE, 32'h20);
		wr(eic_pkg::OFS_EV_IRQ_EN, 32'h0);
		repeat (8) @(posedge pclk);
		wr(eic_pkg::OFS_EV_PEND, 32'h001f_ffff);
		@(posedge pclk);
		gpio_in[23] <= 1'b1;
		#2;
		gpio_in[23] <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(eic_pkg::OFS_EV_PEND, 32'h20);
		check("line_irq", {11'h0, line_irq}, 32'h0);
		wr(eic_pkg::OFS_EV_PEND, 32'h0);
		rd(eic_pkg::OFS_EV_PEND, 32'h20);
		wr(eic_pkg::OFS_EV_IRQ_EN, 32'h20);
		check("line_irq", {11'h0, line_irq}, 32'h20);
		wr(eic_pkg::OFS_EV_PEND, 32'h20);
		rd(eic_pkg::OFS_EV_PEND, 32'h0);
		// Interrupt 9 at priority 1, 3 at priority 3, 7 at priority 0
		wr(eic_pkg::OFS_VTOR, 32'h200);
		wr(eic_pkg::OFS_IRQ_EN, 32'hffff_ffff);
		wr(eic_pkg::OFS_IRQ_PRIO0, 32'h0004_00c0);
		raise(1'b0, 10'h0, 32'h200);
		take(6'd25, 1'b0);
		ack_wait <= 4'd10;
		raise(1'b0, 10'h0, 32'h8);
		repeat (10) @(posedge pclk);
		check("disp_valid", {31'h0, disp_valid}, 32'h0);
		raise(1'b0, 10'h0, 32'h80);
		take(6'd23, 1'b0);
		end_handler(1'b1);
		end_handler(1'b0);
		take(6'd19, 1'b1);
		raise(1'b1, 10'h0, 32'h0);
		take(eic_pkg::NUM_NMI, 1'b0);
		end_handler(1'b1);
		raise(1'b0, 10'h4, 32'h0);
		take(eic_pkg::NUM_EXC0 + 6'd2, 1'b0);
		end_handler(1'b1);
		end_handler(1'b1);
		// A disabled request still pends but is never offered
		wr(eic_pkg::OFS_IRQ_EN, 32'h0);
		raise(1'b0, 10'h0, 32'h10);
		repeat (4) @(posedge pclk);
		check("disp_valid", {31'h0, disp_valid}, 32'h0);
		rd(eic_pkg::OFS_IRQ_PEND, 32'h10);
		wr(eic_pkg::OFS_IRQ_PEND, 32'h10);
		rd(eic_pkg::OFS_IRQ_PEND, 32'h0);
		// Reset in mid-run drops a standing line request and the masks
		wr(eic_pkg::OFS_EV_IRQ_EN, 32'h20);
		gpio_in[23] <= 1'b1;
		repeat (8) @(posedge pclk);
		check("line_irq", {11'h0, line_irq}, 32'h20);
		presetn <= 1'b0;
		gpio_in[23] <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("line_irq", {11'h0, line_irq}, 32'h0);
		rd(eic_pkg::OFS_EV_IRQ_EN, 32'h0);
		rd(eic_pkg::OFS_STATUS, 32'h0000_0600);
		summarize();
	end
	initial begin
		repeat (6000) @(posedge pclk);
		failures++;
		summarize();
	end
endmodule : eic_ctrl_test
